// ### hdl/ioc_defs.vh
// Constants for the input overcurrent fault-response sequencer
`ifndef IOC_DEFS_VH
`define IOC_DEFS_VH
`define IOC_ACTION_OFFSET   8'h5C
`define IOC_ACTION_RESET    8'h00
`define IOC_RESP_MSB        7
`define IOC_RESP_LSB        6
`define IOC_RETRY_MSB       5
`define IOC_RETRY_LSB       3
`define IOC_DELAY_MSB       2
`define IOC_DELAY_LSB       0
`define IOC_RESP_IGNORE     2'h0
`define IOC_RESP_RIDE       2'h1
`define IOC_RESP_SHUTDOWN   2'h2
`define IOC_RESP_WAIT_CLEAR 2'h3
`define IOC_RETRY_INFINITE  3'h7
`define IOC_CLK_HZ          50000000
`define IOC_CYC_PER_MS      (`IOC_CLK_HZ / 1000)
`define IOC_DLY1_BASE_MS    12'h00A
`define IOC_DLY2_MS_0       12'h0FC
`define IOC_DLY2_MS_1       12'h22E
`define IOC_DLY2_MS_2       12'h39C
`define IOC_DLY2_MS_3       12'h4EC
`define IOC_DLY2_MS_4       12'h63C
`define IOC_DLY2_MS_5       12'h78C
`define IOC_DLY2_MS_6       12'h8DC
`define IOC_DLY2_MS_7       12'hA2C
`endif

// ### hdl/ioc_fault_seq.v
// Input overcurrent fault-response sequencer with its action register
//
// Summary of operation
// - Action bits 7:6 pick one of four responses; 00 ignores the fault.
// - Code 01 rides through delay one, then shuts down and retries if fault remains.
// - Code 10 disables the output at once, then retries per retry field.
// - Code 11 holds output off while fault persists, re-enables when cleared.
// - Bits 5:3 give retry count; 000 none, 001 one retry.
// - After retries run out with fault present, output latches off.
// - Latched fault clears only by reset, power cycle or bias loss.
// - Restart attempts are spaced by delay two, chosen by bits 2:0.
// - Delay one doubles from 10 ms; delay two runs from 252 ms upward.
`include "ioc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ioc_fault_seq #(
  parameter CYC_PER_MS = `IOC_CYC_PER_MS
) (
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  input  wire       i_fault,
  input  wire [7:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_wr,
  output reg  [7:0] o_reg_rdata,
  output reg        o_output_en,
  output reg        o_fault_latched,
  output reg  [2:0] o_state
);
  // Binary state codes, mirrored on o_state for observation
  localparam ST_RUN     = 3'h0;
  localparam ST_RIDE    = 3'h1;
  localparam ST_OFF     = 3'h2;
  localparam ST_HOLD    = 3'h3;
  localparam ST_LATCHED = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Fault input synchroniser
  // Only the second stage feeds logic; the first may go metastable
  reg fault_meta_reg;
  reg fault_sync_reg;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_meta_reg <= 1'b0;
      fault_sync_reg <= 1'b0;
    end else begin
      fault_meta_reg <= i_fault;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Action register
  // Codes are read live, so a rewrite steers the very next decision
  // of the sequencer; the reset value ignores faults
  reg [7:0] action_reg;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      action_reg <= `IOC_ACTION_RESET;
    end else if (i_reg_wr && i_reg_addr == `IOC_ACTION_OFFSET) begin
      action_reg <= i_reg_wdata;
    end
  end

  wire [1:0] resp  = action_reg[`IOC_RESP_MSB:`IOC_RESP_LSB];
  wire [2:0] retry = action_reg[`IOC_RETRY_MSB:`IOC_RETRY_LSB];
  wire [2:0] dsel  = action_reg[`IOC_DELAY_MSB:`IOC_DELAY_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Delay tables in milliseconds
  // Loaded when a wait starts, so a rewrite of bits 2:0 only
  // affects the next wait, never one already running
  wire [11:0] dly1_ms = `IOC_DLY1_BASE_MS << dsel;
  reg  [11:0] dly2_ms;
  always @* begin
    case (dsel)
      3'h0:    dly2_ms = `IOC_DLY2_MS_0;
      3'h1:    dly2_ms = `IOC_DLY2_MS_1;
      3'h2:    dly2_ms = `IOC_DLY2_MS_2;
      3'h3:    dly2_ms = `IOC_DLY2_MS_3;
      3'h4:    dly2_ms = `IOC_DLY2_MS_4;
      3'h5:    dly2_ms = `IOC_DLY2_MS_5;
      3'h6:    dly2_ms = `IOC_DLY2_MS_6;
      default: dly2_ms = `IOC_DLY2_MS_7;
    endcase
  end

  // One free-running tick; the first tick of a wait lands anywhere
  // in its millisecond, so every delay may run up to 1 ms short
  wire ms_tick;
  ioc_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .o_tick    (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Retry model: each end of a delay-two wait is one restart attempt.
  // Fault gone at that moment restarts the output; fault still there
  // spends one retry, or latches off once the retry count is used up.
  // Fault is looked at only when a wait ends, so a short blip of the
  // fault during the wait neither restarts nor latches.
  // The retry counter is cleared whenever a fresh shutdown begins.
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [11:0] ms_reg;
  reg [11:0] ms_next;
  reg [2:0]  tries_reg;
  reg [2:0]  tries_next;

  // Retries left: infinite code never advances the tries count
  wire can_retry = (retry == `IOC_RETRY_INFINITE) || (tries_reg < retry);
  wire ms_done   = ms_tick && (ms_reg == 12'h001);
  wire [11:0] ms_dec = (ms_tick && ms_reg != 12'h000) ? ms_reg - 12'h001 : ms_reg;

  always @* begin
    state_next = state_reg;
    ms_next    = ms_dec;
    tries_next = tries_reg;
    case (state_reg)
      ST_RUN: begin
        // Ignore code falls to the default branch and stays running
        if (fault_sync_reg) begin
          case (resp)
            `IOC_RESP_RIDE: begin
              state_next = ST_RIDE;
              ms_next    = dly1_ms;
            end
            `IOC_RESP_SHUTDOWN: begin
              state_next = ST_OFF;
              ms_next    = dly2_ms;
              tries_next = 3'h0;
            end
            `IOC_RESP_WAIT_CLEAR: state_next = ST_HOLD;
            default: state_next = ST_RUN;
          endcase
        end
      end
      ST_RIDE: begin
        // Output stays on through delay one; a cleared fault ends the ride
        if (!fault_sync_reg) begin
          state_next = ST_RUN;
        end else if (ms_done) begin
          state_next = ST_OFF;
          ms_next    = dly2_ms;
          tries_next = 3'h0;
        end
      end
      ST_OFF: begin
        // Retry spacing; fault sampled when the wait ends
        if (ms_done) begin
          if (!fault_sync_reg) begin
            state_next = ST_RUN;
          end else if (can_retry) begin
            ms_next = dly2_ms;
            if (retry != `IOC_RETRY_INFINITE) begin
              tries_next = tries_reg + 3'h1;
            end
          end else begin
            state_next = ST_LATCHED;
          end
        end
      end
      ST_HOLD: begin
        // No timer here: output returns once the synced fault drops
        if (!fault_sync_reg) begin
          state_next = ST_RUN;
        end
      end
      // Only reset leaves this state; a cleared fault does not
      ST_LATCHED: state_next = ST_LATCHED;
      default: state_next = ST_RUN;
    endcase
  end

  // Next values of the registered outputs; enable and latch flag are decoded from the next state
  // so that each flips on the same edge as the state itself, read data from the address
  wire       out_en_next  = (state_next == ST_RUN) || (state_next == ST_RIDE);
  wire       latched_next = (state_next == ST_LATCHED);
  wire [7:0] rdata_next   = (i_reg_addr == `IOC_ACTION_OFFSET) ? action_reg : 8'h00;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_RUN;
      ms_reg    <= 12'h000;
      tries_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      ms_reg    <= ms_next;
      tries_reg <= tries_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Output enable comes up high in reset: nothing is latched after power-up
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_en     <= 1'b1;
      o_fault_latched <= 1'b0;
      o_state         <= ST_RUN;
    end else begin
      o_output_en     <= out_en_next;
      o_fault_latched <= latched_next;
      o_state         <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  // Registered, so a read answers one edge after the address is set
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ### hdl/ioc_ms_tick.v
// Millisecond tick generator for the fault sequencer timers
`include "ioc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ioc_ms_tick #(
  parameter CYC_PER_MS = `IOC_CYC_PER_MS
) (
  input  wire i_clk_sys,
  input  wire i_rst_n,
  output reg  o_tick
);
  reg [31:0] cnt_reg;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 32'h0000_0000;
      o_tick  <= 1'b0;
    end else if (cnt_reg >= CYC_PER_MS - 1) begin
      cnt_reg <= 32'h0000_0000;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      o_tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/ioc_fault_seq_asserts.sv
// Port-level checker for the input overcurrent fault sequencer
`timescale 1ns/1ps
`default_nettype none
module ioc_fault_seq_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_fault,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_output_en,
  input wire logic       o_fault_latched,
  input wire logic [2:0] o_state
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr;
    (i_reg_wr && i_reg_addr == 8'h5C) ##1 (!i_reg_wr && i_reg_addr == 8'h5C);
  endsequence
  sequence s_clear;
    (o_state == 3'h3 && !i_fault) ##1 (!i_fault) [*2];
  endsequence
  property p_wr; s_wr |=> o_reg_rdata == $past(i_reg_wdata, 2); endproperty
  property p_unmapped; i_reg_addr != 8'h5C |=> o_reg_rdata == 8'h00; endproperty
  property p_ride;
    o_state == 3'h1 && !$past(i_fault, 2) |=> o_state == 3'h0 && o_output_en;
  endproperty
  property p_shut;
    o_state == 3'h2 && $past(i_fault, 2) |=> !o_output_en;
  endproperty
  property p_hold;
    o_state == 3'h3 && $past(i_fault, 2) |=> o_state == 3'h3 && !o_output_en;
  endproperty
  property p_resume; s_clear |-> ##[1:5] o_output_en; endproperty
  property p_latch;
    $rose(o_fault_latched) |-> $past(o_state) == 3'h2 && $past(i_fault, 3) && !o_output_en;
  endproperty
  property p_sticky; o_fault_latched |=> o_fault_latched; endproperty
  a_wr:       assert property (p_wr) else $error("action register readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ride:     assert property (p_ride) else $error("ride did not end on clear");
  a_shut:     assert property (p_shut) else $error("output on in retry wait");
  a_hold:     assert property (p_hold) else $error("output on while holding");
  a_resume:   assert property (p_resume) else $error("no resume after clear");
  a_latch:    assert property (p_latch) else $error("latched without failed retry");
  a_sticky:   assert property (p_sticky) else $error("latch dropped without reset");
endmodule
bind ioc_fault_seq ioc_fault_seq_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_fault(i_fault), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .o_reg_rdata(o_reg_rdata), .o_output_en(o_output_en), .o_fault_latched(o_fault_latched),
  .o_state(o_state));
`default_nettype wire

// ### verif/tb_ioc_fault_seq.sv
// Self-checking bench for the input overcurrent fault sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_ioc_fault_seq;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       fault = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  wire  [7:0] rdata;
  wire        en;
  wire        lat;
  wire  [2:0] st;
  integer     bad_count = 0;
  integer     n_compared = 0;
  integer     i;
  always #10 clk = ~clk;
  // Short millisecond so delay two of code 000 is 1260 cycles
  ioc_fault_seq #(.CYC_PER_MS(5)) i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_fault(fault),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
    .o_output_en(en), .o_fault_latched(lat), .o_state(st));
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    addr = a;
    cyc(2);
    chk(rdata, exp);
  endtask
  task rst;
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
  endtask
  task summarize;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst;
    rd(8'h5C, 8'h00);
    chk(en, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(8'h5C, {i[1:0], 6'h15});
      rd(8'h5C, {i[1:0], 6'h15});
    end
    rd(8'h5B, 8'h00);
    wr_reg(8'h5C, 8'h00);
    fault = 1'b1;
    cyc(200);
    chk(en, 8'h01);
    fault = 1'b0;
    wr_reg(8'h5C, 8'h40);
    fault = 1'b1;
    cyc(20);
    fault = 1'b0;
    cyc(80);
    chk(en, 8'h01);
    fault = 1'b1;
    cyc(40);
    chk(en, 8'h01);
    cyc(40);
    chk(en, 8'h00);
    cyc(1300);
    chk(lat, 8'h01);
    fault = 1'b0;
    cyc(50);
    chk(en, 8'h00);
    rst;
    chk(lat, 8'h00);
    wr_reg(8'h5C, 8'h88);
    fault = 1'b1;
    cyc(6);
    chk(en, 8'h00);
    cyc(1294);
    chk(lat, 8'h00);
    cyc(1300);
    chk(lat, 8'h01);
    fault = 1'b0;
    rst;
    // Delay code 001: ride doubles to 20 ms, retry spacing becomes 558 ms
    wr_reg(8'h5C, 8'h41);
    fault = 1'b1;
    cyc(90);
    chk(en, 8'h01);
    cyc(20);
    chk(en, 8'h00);
    cyc(2700);
    chk(lat, 8'h00);
    cyc(100);
    chk(lat, 8'h01);
    chk(st, 8'h04);
    fault = 1'b0;
    rst;
    wr_reg(8'h5C, 8'hC0);
    fault = 1'b1;
    cyc(300);
    chk(en, 8'h00);
    chk(st, 8'h03);
    fault = 1'b0;
    cyc(8);
    chk(en, 8'h01);
    // Unlimited retries must never latch, however long the fault stays
    wr_reg(8'h5C, 8'hB8);
    fault = 1'b1;
    cyc(4000);
    chk(lat, 8'h00);
    fault = 1'b0;
    cyc(1300);
    chk(en, 8'h01);
    summarize;
  end
endmodule
`default_nettype wire
